// ==== logic/ddc_params.svh ====
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////
// Register addresses on the serial port
`define DDC_ADDR_MODE       7'h00
`define DDC_ADDR_B_GAIN_LO  7'h0d
`define DDC_ADDR_B_GAIN_HI  7'h0e
`define DDC_ADDR_OPTION     7'h0f
`define DDC_ADDR_TIMEREF    7'h10
`define DDC_ADDR_TUNE_A     7'h11
`define DDC_ADDR_TUNE_B     7'h13
`define DDC_ADDR_TUNE_C     7'h14
`define DDC_ADDR_AUX_A_HI   7'h1a
`define DDC_ADDR_AUX_A_LO   7'h1b
`define DDC_ADDR_AUX_B_HI   7'h1c
`define DDC_ADDR_AUX_B_LO   7'h1d

////////////////////////////////////////////////////////////////////////
// Field positions
`define DDC_MODE_BIT        3
`define DDC_GAIN_CUT_BIT    1
`define DDC_SHAPER_BIT      0
`define DDC_SYNC_DIV_BIT    7
`define DDC_SYNC_EN_BIT     6
`define DDC_PD_BIT          7
`define DDC_HI_LSB          6
`define DDC_AUX_LO_W        2
`define DDC_AUX_W           10
`define DDC_SYNC_DIV4_TAP   1
`define DDC_SYNC_DIV8_TAP   2

////////////////////////////////////////////////////////////////////////
// Reset values and counts
`define DDC_RST_BYTE        8'h00
`define DDC_RST_BIT         1'b0
`define DDC_BYTE_LAST       3'h7
`define DDC_SAMPLE_W        14

`endif

// ==== logic/ddc_pkg.sv ====
`default_nettype none
`include "ddc_params.svh"

package ddc_pkg;

  typedef logic [`DDC_SAMPLE_W-1:0] ddc_word_t;

  // One I/Q sample pair handed to the converter latches
  typedef struct packed {
    ddc_word_t i;
    ddc_word_t q;
  } ddc_pair_t;

  // Serial port phase, Gray coded along idle-command-data-done
  typedef enum logic [1:0] {
    DDC_SP_IDLE = 2'b00,
    DDC_SP_CMD  = 2'b01,
    DDC_SP_DATA = 2'b11,
    DDC_SP_DONE = 2'b10
  } ddc_spi_ph_t;

  // Configuration held by the register file
  typedef struct packed {
    logic                      mode_ileave;
    logic [7:0]                b_gain_lo;
    logic [7:0]                b_gain_hi;
    logic                      gain_cut;
    logic                      shaper_en;
    logic                      sync_div8;
    logic                      sync_en;
    logic [7:0]                tune_a;
    logic [7:0]                tune_b;
    logic [7:0]                tune_c;
    logic [`DDC_AUX_W-1:0]     aux_a;
    logic                      aux_chan_a_powerdown;
    logic [`DDC_AUX_W-1:0]     aux_b;
    logic                      aux_chan_b_powerdown;
  } ddc_regs_t;

  // Whole state of the top module
  typedef struct packed {
    ddc_regs_t   regs;
    ddc_spi_ph_t ph;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift_in;
    logic [6:0]  addr;
    logic        rd;
    logic [7:0]  tx;
    logic        sdo;
    logic        sdo_oe;
    logic        sclk_d;
    logic        dclk_d;
    logic        iq_d;
    logic        sync_d;
    logic [2:0]  sync_cnt;
    logic        sync_out;
    logic        expect_i;
    ddc_word_t   hold_i;
    logic        overrun;
  } ddc_state_t;

endpackage

`default_nettype wire

// ==== logic/ddc_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

module ddc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ddc_sync_st_t;

  ddc_sync_st_t st_r;
  ddc_sync_st_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
  end

  // Two flops per bit against metastability
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.s2;

endmodule

`default_nettype wire

// ==== logic/ddc_fifo2.sv ====
`timescale 1ns/1ps
`default_nettype none

module ddc_fifo2 #(
  parameter int W = 28
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } ddc_fifo_st_t;

  ddc_fifo_st_t st_r;
  ddc_fifo_st_t st_nxt;
  logic         do_wr;
  logic         do_rd;

  // Two slots; full only when both hold a word
  always_comb begin
    st_nxt = st_r;
    do_wr  = in_valid_i && (st_r.cnt != 2'h2);
    do_rd  = out_ready_i && (st_r.cnt != 2'h0);
    if (do_wr) begin
      st_nxt.slot[st_r.wp] = in_data_i;
      st_nxt.wp            = ~st_r.wp;
    end
    if (do_rd) begin
      st_nxt.rp = ~st_r.rp;
    end
    st_nxt.cnt = st_r.cnt + {1'b0, do_wr} - {1'b0, do_rd};
  end

  // Slots are flops, so read data comes from a register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready_o  = (st_r.cnt != 2'h2);
  assign out_valid_o = (st_r.cnt != 2'h0);
  assign out_data_o  = st_r.slot[st_r.rp];

endmodule

`default_nettype wire

// ==== logic/ddc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"

module ddc_top (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // Serial register port
  input  wire logic                      spi_sclk_i,
  input  wire logic                      spi_cs_n_i,
  input  wire logic                      spi_sdi_i,
  output logic                           spi_sdo_o,
  output logic                           spi_sdo_oe_o,
  // Sample input pins
  input  wire logic                      data_clk_i,
  input  wire logic [`DDC_SAMPLE_W-1:0]  bus_i_i,
  input  wire logic [`DDC_SAMPLE_W-1:0]  bus_q_i,
  // Timing reference select, same clock domain
  input  wire logic                      pll_bypass_i,
  output logic                           sync_o,
  // Sample pairs towards the converter latches
  output logic                           smp_valid_o,
  input  wire logic                      smp_ready_i,
  output ddc_pkg::ddc_pair_t             smp_data_o,
  output logic                           smp_overrun_o,
  // Configuration outputs
  output logic                           mode_ileave_o,
  output logic [3:0]                     chan_b_gain_coarse_o,
  output logic [5:0]                     chan_b_gain_fine_o,
  output logic [5:0]                     chan_b_offset_hi_o,
  output logic                           modulator_gain_cut_o,
  output logic                           noise_shaping_enable_o,
  output logic [7:0]                     tuning_word_a_o,
  output logic [7:0]                     tuning_word_b_o,
  output logic [7:0]                     tuning_word_c_o,
  output logic [`DDC_AUX_W-1:0]          aux_a_level_o,
  output logic                           aux_chan_a_powerdown_o,
  output logic [`DDC_AUX_W-1:0]          aux_b_level_o,
  output logic                           aux_chan_b_powerdown_o
);

  localparam int PINS_W = 4 + 2 * `DDC_SAMPLE_W;

  ddc_pkg::ddc_state_t st_r;
  ddc_pkg::ddc_state_t st_nxt;
  logic [PINS_W-1:0]   pins_s;
  logic                sclk_s;
  logic                cs_n_s;
  logic                sdi_s;
  logic                dclk_s;
  ddc_pkg::ddc_word_t  bus_i_s;
  ddc_pkg::ddc_word_t  bus_q_s;
  logic                iq_steering_input;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                dclk_rise;
  logic                iq_rise;
  logic                sync_rise;
  logic                cap_stb;
  logic                push_v;
  ddc_pkg::ddc_pair_t  push_d;
  logic                push_rdy;
  logic [7:0]          wr_byte;

  ////////////////////////////////////////////////////////////////////////
  // Read-back decode, reserved bits forced to zero
  function automatic logic [7:0] rd_byte(input ddc_pkg::ddc_regs_t r, input logic [6:0] a);
    logic [7:0] v;
    v = `DDC_RST_BYTE;
    case (a)
      `DDC_ADDR_MODE:      v[`DDC_MODE_BIT] = r.mode_ileave;
      `DDC_ADDR_B_GAIN_LO: v = r.b_gain_lo;
      `DDC_ADDR_B_GAIN_HI: v = r.b_gain_hi;
      `DDC_ADDR_OPTION: begin
        v[`DDC_GAIN_CUT_BIT] = r.gain_cut;
        v[`DDC_SHAPER_BIT]   = r.shaper_en;
      end
      `DDC_ADDR_TIMEREF: begin
        v[`DDC_SYNC_DIV_BIT] = r.sync_div8;
        v[`DDC_SYNC_EN_BIT]  = r.sync_en;
      end
      `DDC_ADDR_TUNE_A:    v = r.tune_a;
      `DDC_ADDR_TUNE_B:    v = r.tune_b;
      `DDC_ADDR_TUNE_C:    v = r.tune_c;
      `DDC_ADDR_AUX_A_HI:  v = r.aux_a[`DDC_AUX_W-1:`DDC_AUX_LO_W];
      `DDC_ADDR_AUX_A_LO: begin
        v[`DDC_PD_BIT]             = r.aux_chan_a_powerdown;
        v[`DDC_AUX_LO_W-1:0]       = r.aux_a[`DDC_AUX_LO_W-1:0];
      end
      `DDC_ADDR_AUX_B_HI:  v = r.aux_b[`DDC_AUX_W-1:`DDC_AUX_LO_W];
      `DDC_ADDR_AUX_B_LO: begin
        v[`DDC_PD_BIT]             = r.aux_chan_b_powerdown;
        v[`DDC_AUX_LO_W-1:0]       = r.aux_b[`DDC_AUX_LO_W-1:0];
      end
      default:             v = `DDC_RST_BYTE;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Serial port and sample link pins pass two flops first; pll_bypass_i and smp_ready_i go straight in
  ddc_sync2 #(
    .W (PINS_W)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({spi_sclk_i, spi_cs_n_i, spi_sdi_i, data_clk_i, bus_i_i, bus_q_i}),
    .sync_o  (pins_s)
  );

  // Unpack the synchronised pins; Q13 doubles as the steering input
  assign {sclk_s, cs_n_s, sdi_s, dclk_s, bus_i_s, bus_q_s} = pins_s;
  assign iq_steering_input = bus_q_s[`DDC_SAMPLE_W-1];

  // Edge finders work only on synchronised copies
  assign sclk_rise = sclk_s & ~st_r.sclk_d;
  assign sclk_fall = ~sclk_s & st_r.sclk_d;
  assign dclk_rise = dclk_s & ~st_r.dclk_d;
  assign iq_rise   = iq_steering_input & ~st_r.iq_d;
  assign sync_rise = st_r.sync_out & ~st_r.sync_d;

  // Reference is the input clock, or the sync output when bypassed
  assign cap_stb = pll_bypass_i ? sync_rise : dclk_rise;

  // Byte being written, assembled from the shift register and last bit
  assign wr_byte = {st_r.shift_in[6:0], sdi_s};

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb begin
    st_nxt   = st_r;
    push_v   = 1'b0;
    push_d   = '0;
    st_nxt.sclk_d = sclk_s;
    st_nxt.dclk_d = dclk_s;
    st_nxt.iq_d   = iq_steering_input;
    st_nxt.sync_d = st_r.sync_out;

    // Serial port: command byte, then one data byte
    if (cs_n_s) begin
      st_nxt.ph      = ddc_pkg::DDC_SP_IDLE;
      st_nxt.sdo_oe  = 1'b0;
      st_nxt.bit_cnt = '0;
    end else begin
      case (st_r.ph)
        ddc_pkg::DDC_SP_IDLE: begin
          st_nxt.ph      = ddc_pkg::DDC_SP_CMD;
          st_nxt.bit_cnt = '0;
        end
        ddc_pkg::DDC_SP_CMD: begin
          if (sclk_rise) begin
            st_nxt.shift_in = wr_byte;
            st_nxt.bit_cnt  = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == `DDC_BYTE_LAST) begin
              st_nxt.rd   = wr_byte[7];
              st_nxt.addr = wr_byte[6:0];
              st_nxt.ph   = ddc_pkg::DDC_SP_DATA;
              if (wr_byte[7]) begin
                st_nxt.tx     = rd_byte(st_r.regs, wr_byte[6:0]);
                st_nxt.sdo    = st_nxt.tx[7];
                st_nxt.sdo_oe = 1'b1;
              end
            end
          end
        end
        ddc_pkg::DDC_SP_DATA: begin
          if (sclk_rise) begin
            st_nxt.shift_in = wr_byte;
            st_nxt.bit_cnt  = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == `DDC_BYTE_LAST) begin
              st_nxt.ph = ddc_pkg::DDC_SP_DONE;
            end
          end else if (sclk_fall && st_r.rd && (st_r.bit_cnt != 3'h0)) begin
            // Next read bit goes out on the falling edge
            st_nxt.tx  = {st_r.tx[6:0], 1'b0};
            st_nxt.sdo = st_r.tx[6];
          end
        end
        ddc_pkg::DDC_SP_DONE: begin
          st_nxt.sdo_oe = 1'b0;
        end
        default: begin
          st_nxt.ph = ddc_pkg::DDC_SP_IDLE;
        end
      endcase
    end

    // Register write on the last data bit; unlisted addresses ignored
    if (!cs_n_s && sclk_rise && (st_r.ph == ddc_pkg::DDC_SP_DATA) &&
        (st_r.bit_cnt == `DDC_BYTE_LAST) && !st_r.rd) begin
      case (st_r.addr)
        `DDC_ADDR_MODE:      st_nxt.regs.mode_ileave = wr_byte[`DDC_MODE_BIT];
        `DDC_ADDR_B_GAIN_LO: st_nxt.regs.b_gain_lo   = wr_byte;
        `DDC_ADDR_B_GAIN_HI: st_nxt.regs.b_gain_hi   = wr_byte;
        `DDC_ADDR_OPTION: begin
          st_nxt.regs.gain_cut  = wr_byte[`DDC_GAIN_CUT_BIT];
          st_nxt.regs.shaper_en = wr_byte[`DDC_SHAPER_BIT];
        end
        `DDC_ADDR_TIMEREF: begin
          st_nxt.regs.sync_div8 = wr_byte[`DDC_SYNC_DIV_BIT];
          st_nxt.regs.sync_en   = wr_byte[`DDC_SYNC_EN_BIT];
        end
        `DDC_ADDR_TUNE_A:    st_nxt.regs.tune_a = wr_byte;
        `DDC_ADDR_TUNE_B:    st_nxt.regs.tune_b = wr_byte;
        `DDC_ADDR_TUNE_C:    st_nxt.regs.tune_c = wr_byte;
        `DDC_ADDR_AUX_A_HI:  st_nxt.regs.aux_a[`DDC_AUX_W-1:`DDC_AUX_LO_W] = wr_byte;
        `DDC_ADDR_AUX_A_LO: begin
          st_nxt.regs.aux_a[`DDC_AUX_LO_W-1:0] = wr_byte[`DDC_AUX_LO_W-1:0];
          st_nxt.regs.aux_chan_a_powerdown                 = wr_byte[`DDC_PD_BIT];
        end
        `DDC_ADDR_AUX_B_HI:  st_nxt.regs.aux_b[`DDC_AUX_W-1:`DDC_AUX_LO_W] = wr_byte;
        `DDC_ADDR_AUX_B_LO: begin
          st_nxt.regs.aux_b[`DDC_AUX_LO_W-1:0] = wr_byte[`DDC_AUX_LO_W-1:0];
          st_nxt.regs.aux_chan_b_powerdown                 = wr_byte[`DDC_PD_BIT];
        end
        default: st_nxt.regs = st_r.regs;
      endcase
    end

    // Sync output divides the input clock by four or eight
    if (dclk_rise) begin
      st_nxt.sync_cnt = st_r.sync_cnt + 3'h1;
    end
    st_nxt.sync_out = st_r.regs.sync_en &&
                      (st_r.regs.sync_div8 ? st_r.sync_cnt[`DDC_SYNC_DIV8_TAP]
                                           : st_r.sync_cnt[`DDC_SYNC_DIV4_TAP]);

    // Steering edge: the word captured now or next goes to I
    if (iq_rise) begin
      st_nxt.expect_i = 1'b1;
    end

    // Capture: a pair offered to a full buffer is dropped, and the loss is flagged
    if (cap_stb) begin
      if (!st_r.regs.mode_ileave) begin
        push_v   = 1'b1;
        push_d.i = bus_i_s;
        push_d.q = bus_q_s;
      end else if (st_r.expect_i || iq_rise) begin
        st_nxt.hold_i   = bus_i_s;
        st_nxt.expect_i = 1'b0;
      end else begin
        push_v          = 1'b1;
        push_d.i        = st_r.hold_i;
        push_d.q        = bus_i_s;
        st_nxt.expect_i = 1'b1;
      end
      if (push_v && !push_rdy) begin
        st_nxt.overrun = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One register for all state; synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r          <= '0;
      st_r.expect_i <= 1'b1;
      st_r.ph       <= ddc_pkg::DDC_SP_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry buffer so a receiver stall loses no pair until both entries are full
  ddc_fifo2 #(
    .W ($bits(ddc_pkg::ddc_pair_t))
  ) u_pair_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_v),
    .in_ready_o  (push_rdy),
    .in_data_i   (push_d),
    .out_valid_o (smp_valid_o),
    .out_ready_i (smp_ready_i),
    .out_data_o  (smp_data_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from state flops
  assign spi_sdo_o              = st_r.sdo;
  assign spi_sdo_oe_o           = st_r.sdo_oe;
  assign sync_o                 = st_r.sync_out;
  assign smp_overrun_o          = st_r.overrun;
  assign mode_ileave_o          = st_r.regs.mode_ileave;
  assign chan_b_gain_coarse_o   = {st_r.regs.b_gain_hi[7:`DDC_HI_LSB],
                                   st_r.regs.b_gain_lo[7:`DDC_HI_LSB]};
  assign chan_b_gain_fine_o     = st_r.regs.b_gain_lo[`DDC_HI_LSB-1:0];
  assign chan_b_offset_hi_o     = st_r.regs.b_gain_hi[`DDC_HI_LSB-1:0];
  assign modulator_gain_cut_o   = st_r.regs.gain_cut;
  assign noise_shaping_enable_o = st_r.regs.shaper_en;
  assign tuning_word_a_o        = st_r.regs.tune_a;
  assign tuning_word_b_o        = st_r.regs.tune_b;
  assign tuning_word_c_o        = st_r.regs.tune_c;
  assign aux_a_level_o          = st_r.regs.aux_a;
  assign aux_chan_a_powerdown_o = st_r.regs.aux_chan_a_powerdown;
  assign aux_b_level_o          = st_r.regs.aux_b;
  assign aux_chan_b_powerdown_o = st_r.regs.aux_chan_b_powerdown;

endmodule

`default_nettype wire

// ==== tb/ddc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"

module ddc_chk (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  // Pins
  input wire logic                  spi_cs_n_i,
  input wire logic                  spi_sdo_oe_o,
  input wire logic                  data_clk_i,
  input wire logic                  pll_bypass_i,
  input wire logic                  sync_o,
  // Sample side
  input wire logic                  smp_valid_o,
  input wire logic                  smp_ready_i,
  input wire ddc_pkg::ddc_pair_t    smp_data_o,
  input wire logic                  smp_overrun_o,
  // Configuration
  input wire logic                  mode_ileave_o,
  input wire logic                  modulator_gain_cut_o,
  input wire logic                  noise_shaping_enable_o,
  input wire logic [`DDC_AUX_W-1:0] aux_a_level_o,
  input wire logic                  aux_chan_a_powerdown_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////
  // Sample path
  hold_pair_a: assert property (smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_data_o))
    else $error("pair changed while stalled");
  // Sync delay plus push leaves a few cycles of slack
  dual_lat_a: assert property (!mode_ileave_o && !pll_bypass_i && $rose(data_clk_i) |-> ##[1:6] smp_valid_o)
    else $error("dual pair not offered in time");
  overrun_keep_a: assert property (smp_overrun_o |=> smp_overrun_o)
    else $error("overrun flag lost");
  quiet_link_a: assert property ($stable(data_clk_i)[*8] ##0 !smp_valid_o |=> !smp_valid_o)
    else $error("pair without a strobe");
  sync_quiet_a: assert property (($stable(data_clk_i) && spi_cs_n_i)[*6] |-> $stable(sync_o))
    else $error("sync moved without link edges");

  ////////////////////////////////////////////////////////////////////////
  // Register port
  sdo_idle_a: assert property (spi_cs_n_i[*6] |-> !spi_sdo_oe_o)
    else $error("sdo driven while deselected");
  cfg_hold_a: assert property (spi_cs_n_i[*6] |-> $stable({mode_ileave_o, modulator_gain_cut_o, noise_shaping_enable_o}))
    else $error("option changed without a frame");
  aux_hold_a: assert property (spi_cs_n_i[*6] |-> $stable({aux_a_level_o, aux_chan_a_powerdown_o}))
    else $error("aux level changed without a frame");
endmodule

bind ddc_top ddc_chk i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i), .spi_sdo_oe_o(spi_sdo_oe_o),
  .data_clk_i(data_clk_i), .pll_bypass_i(pll_bypass_i), .sync_o(sync_o), .smp_valid_o(smp_valid_o),
  .smp_ready_i(smp_ready_i), .smp_data_o(smp_data_o), .smp_overrun_o(smp_overrun_o),
  .mode_ileave_o(mode_ileave_o), .modulator_gain_cut_o(modulator_gain_cut_o),
  .noise_shaping_enable_o(noise_shaping_enable_o), .aux_a_level_o(aux_a_level_o),
  .aux_chan_a_powerdown_o(aux_chan_a_powerdown_o)
);

`default_nettype wire

// ==== tb/ddc_src.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"

module ddc_src (
  // Link pins towards the block
  output logic                     data_clk_o,
  output logic [`DDC_SAMPLE_W-1:0] bus_i_o,
  output logic [`DDC_SAMPLE_W-1:0] bus_q_o
);
  initial begin
    data_clk_o = 1'b0;
    bus_i_o = '0;
    bus_q_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst of n words; clock stands low between bursts, words change on the low phase
  task automatic burst(input int n, input logic [13:0] base, input bit il, input bit hold);
    logic [13:0] w;
    #3;
    for (int k = 0; k < n; k++) begin
      w = hold ? base : base + 14'(k);
      bus_i_o = w;
      bus_q_o = il ? {k == 0, 13'h0} : ~w;
      #80 data_clk_o = 1'b1;
      #80 data_clk_o = 1'b0;
    end
    // Released bus shows the inverse, with Q13 held low, so a late capture cannot pass
    bus_i_o = ~w;
    bus_q_o = ~bus_q_o & 14'h1fff;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"

module tb;
  logic               clk_i, rst_n_i, sclk, cs_n, sdi, ready, byp;
  logic               sdo, sdo_oe, sync, valid, ovr, mode, cut, shp, apd, bpd, data_clk;
  logic [13:0]        bus_i, bus_q;
  logic [3:0]         coarse;
  logic [5:0]         fine, offs;
  logic [7:0]         tw_a, tw_b, tw_c, q, p;
  logic [9:0]         aux_a, aux_b;
  ddc_pkg::ddc_pair_t data;
  ddc_pkg::ddc_pair_t rxq[$];
  int                 n_errors = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  logic [6:0]         addrs[13] = '{7'h00, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h13, 7'h14, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h05};
  logic [7:0]         masks[13] = '{8'h08, 8'hff, 8'hff, 8'h03, 8'hc0, 8'hff, 8'hff, 8'hff, 8'hff, 8'h83, 8'hff, 8'h83, 8'h00};
  logic [7:0]         pats[2] = '{8'h5a, 8'ha5};

  ddc_top i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .data_clk_i(data_clk), .bus_i_i(bus_i), .bus_q_i(bus_q),
    .pll_bypass_i(byp), .sync_o(sync), .smp_valid_o(valid), .smp_ready_i(ready), .smp_data_o(data),
    .smp_overrun_o(ovr), .mode_ileave_o(mode), .chan_b_gain_coarse_o(coarse), .chan_b_gain_fine_o(fine),
    .chan_b_offset_hi_o(offs), .modulator_gain_cut_o(cut), .noise_shaping_enable_o(shp),
    .tuning_word_a_o(tw_a), .tuning_word_b_o(tw_b), .tuning_word_c_o(tw_c), .aux_a_level_o(aux_a),
    .aux_chan_a_powerdown_o(apd), .aux_b_level_o(aux_b), .aux_chan_b_powerdown_o(bpd)
  );

  ddc_src i_src (.data_clk_o(data_clk), .bus_i_o(bus_i), .bus_q_o(bus_q));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Receiver log and hang guard; ceiling is about twice the planned run
  // Logged on the falling edge: valid is launched by the rising edge, so this avoids a race
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    if (valid === 1'b1 && ready === 1'b1) rxq.push_back(data);
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One frame; sdo read late in each data-byte high phase, after it has settled
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] f;
    f = {rd, a, d};
    r = '0;
    cs_n <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      tick(4);
      sdi <= f[15-k];
      tick(4);
      sclk <= 1'b1;
      tick(6);
      if (k >= 8) r[15-k] = sdo;
      tick(2);
      sclk <= 1'b0;
    end
    tick(8);
    cs_n <= 1'b1;
    tick(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    ready = 1'b1;
    byp = 1'b0;
    tick(10);
    rst_n_i <= 1'b1;
    tick(4);
    for (int r = 0; r < 13; r++) begin
      xfer(1'b1, addrs[r], 8'h00, q);
      check("reset value", q, 0);
    end
    // Both patterns together set and clear every bit
    foreach (pats[j]) begin
      p = pats[j];
      for (int r = 0; r < 13; r++) xfer(1'b0, addrs[r], p, q);
      for (int r = 0; r < 13; r++) begin
        xfer(1'b1, addrs[r], 8'h00, q);
        check("readback", q, p & masks[r]);
      end
      check("aux a", {aux_a, apd}, {p, p[1:0], p[7]});
      check("aux b", {aux_b, bpd}, {p, p[1:0], p[7]});
      check("chan b", {coarse, fine, offs}, {p[7:6], p[7:6], p[5:0], p[5:0]});
      check("options", {mode, cut, shp}, {p[3], p[1], p[0]});
      check("tuning", {tw_a, tw_b, tw_c}, {3{p}});
    end
    $display("test registers done");
    xfer(1'b0, 7'h00, 8'h00, q);
    xfer(1'b0, 7'h10, 8'h00, q);
    xfer(1'b0, 7'h11, 8'h0a, q);
    xfer(1'b0, 7'h13, 8'h6c, q);
    xfer(1'b0, 7'h14, 8'h6c, q);
    rxq.delete();
    i_src.burst(4, 14'h100, 1'b0, 1'b0);
    tick(20);
    check("dual count", rxq.size(), 4);
    foreach (rxq[k]) check("dual pair", rxq[k], {14'h100 + 14'(k), ~(14'h100 + 14'(k))});
    check("sync off", sync, 0);
    $display("test dual done");
    xfer(1'b0, 7'h00, 8'h08, q);
    rxq.delete();
    i_src.burst(6, 14'h200, 1'b1, 1'b0);
    tick(20);
    check("interleaved count", rxq.size(), 3);
    foreach (rxq[k]) check("interleaved pair", rxq[k], {14'h200 + 14'(2*k), 14'h200 + 14'(2*k+1)});
    $display("test interleaved done");
    xfer(1'b0, 7'h00, 8'h00, q);
    xfer(1'b0, 7'h10, 8'h40, q);
    byp <= 1'b1;
    rxq.delete();
    i_src.burst(12, 14'h300, 1'b0, 1'b1);
    tick(20);
    check("bypass count", rxq.size() > 1, 1);
    foreach (rxq[k]) check("bypass pair", rxq[k], {14'h300, ~14'h300});
    $display("test bypass done");
    byp <= 1'b0;
    ready <= 1'b0;
    rxq.delete();
    i_src.burst(3, 14'h400, 1'b0, 1'b0);
    tick(20);
    check("overrun", {valid, ovr}, 2'b11);
    ready <= 1'b1;
    tick(10);
    check("stall count", rxq.size(), 2);
    foreach (rxq[k]) check("stall pair", rxq[k], {14'h400 + 14'(k), ~(14'h400 + 14'(k))});
    $display("test stall done");
    results();
  end
endmodule

`default_nettype wire
